// ===== adport_regs.svh
`ifndef ADPORT_REGS_SVH
`define ADPORT_REGS_SVH

// register offsets
`define ADPORT_OFS_OUTPUT_DATA   6'h30
`define ADPORT_OFS_PIN_INPUT     6'h31
`define ADPORT_OFS_DIRECTION     6'h32
`define ADPORT_OFS_DRIVE         6'h33
`define ADPORT_OFS_PULL_ENABLE   6'h34
`define ADPORT_OFS_PULL_POLARITY 6'h35

// reset values
`define ADPORT_RST_OUTPUT_DATA   8'h00
`define ADPORT_RST_DIRECTION     8'h00
`define ADPORT_RST_DRIVE         8'h00
`define ADPORT_RST_PULL_ENABLE   8'h00
`define ADPORT_RST_PULL_POLARITY 8'h00

// readback lag after a direction change, in bus cycles
`define ADPORT_SYNC_LAG          2

`endif

// ===== adport_pkg.sv
package adport_pkg;
    typedef logic [7:0] port_byte_t;
    typedef logic [5:0] reg_addr_t;
endpackage

// ===== analog_shared_gpio_port_regs.sv
// Behaviour
// [RULE1] data register reads stored bit if output, synced pin if input
// [RULE2] input register always reads synchronised pins; writes are ignored
// [RULE3] direction 0 makes pin an input, 1 an output from data register
// [RULE4] readback may lag direction change by up to two bus cycles
// [RULE5] reduced-drive bit selects drive strength only when pin is output
// [RULE6] pull enable acts only while pin is an input
// [RULE7] all pull devices disabled after reset
// [RULE8] pull stays off while the pin's converter channel is enabled
// [RULE9] pull enable 0 disables pull, 1 enables polarity-selected pull
// [RULE10] polarity picks up or down, effective only when enabled and input
// [RULE11] config writable any time, applied only when pin use permits
// [RULE12] pin serves as general I/O or as peripheral output or input
// [RULE13] pull-up never active while pin is a push-pull output
// [RULE14] direction bit ignored while a peripheral controls the pin
// [RULE15] data writes reach pin only while pin is a general output
// [RULE16] polarity 0 pull-up, 1 pull-down; drive 0 full, 1 reduced
`timescale 1ns/1ps
`include "adport_regs.svh"

module analog_shared_gpio_port_regs #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_sys_rst,
    // register port
    input  wire adport_pkg::reg_addr_t  i_addr,
    input  wire adport_pkg::port_byte_t i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic [WIDTH-1:0]            o_rdata,
    // peripheral sharing
    input  wire logic [WIDTH-1:0]       i_periph_own,
    input  wire logic [WIDTH-1:0]       i_periph_oe,
    input  wire logic [WIDTH-1:0]       i_periph_out,
    input  wire logic [WIDTH-1:0]       i_adc_chan_en,
    output logic [WIDTH-1:0]            o_periph_in,
    // pins
    input  wire logic [WIDTH-1:0]       i_pin,
    output logic [WIDTH-1:0]            o_pin,
    output logic [WIDTH-1:0]            o_pin_oe,
    output logic [WIDTH-1:0]            o_pin_reduced,
    output logic [WIDTH-1:0]            o_pull_up_en,
    output logic [WIDTH-1:0]            o_pull_dn_en
);

    logic [WIDTH-1:0] output_data;
    logic [WIDTH-1:0] direction;
    logic [WIDTH-1:0] drive_strength;
    logic [WIDTH-1:0] pull_enable;
    logic [WIDTH-1:0] pull_polarity;
    logic [WIDTH-1:0] pin_meta;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] next_oe;
    logic [WIDTH-1:0] next_pin;
    logic [WIDTH-1:0] next_pull_on;
    logic [WIDTH-1:0] next_rdata;
    logic [WIDTH-1:0] wr_val;

    // write data trimmed to the port width once, shared by every register
    assign wr_val = i_wdata[WIDTH-1:0];

    // register writes; every register but the input register accepts a write at any time
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            output_data    <= WIDTH'(`ADPORT_RST_OUTPUT_DATA);
            direction      <= WIDTH'(`ADPORT_RST_DIRECTION);
            drive_strength <= WIDTH'(`ADPORT_RST_DRIVE);
            pull_enable    <= WIDTH'(`ADPORT_RST_PULL_ENABLE); // RULE7
            pull_polarity  <= WIDTH'(`ADPORT_RST_PULL_POLARITY);
        end else if (i_wr) begin // RULE11
            unique case (i_addr)
                `ADPORT_OFS_OUTPUT_DATA:   output_data    <= wr_val;
                `ADPORT_OFS_DIRECTION:     direction      <= wr_val;
                `ADPORT_OFS_DRIVE:         drive_strength <= wr_val;
                `ADPORT_OFS_PULL_ENABLE:   pull_enable    <= wr_val;
                `ADPORT_OFS_PULL_POLARITY: pull_polarity  <= wr_val;
                default: ; // input register and unmapped: ignored   RULE2
            endcase
        end
    end

    // two-stage pin synchroniser; this is why readback lags direction
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= i_pin;
            pin_sync <= pin_meta; // RULE4
        end
    end

    // pin control: peripheral ownership overrides the direction bit
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (i_periph_own[i]) begin // RULE14 RULE12
                next_oe[i]  = i_periph_oe[i];
                next_pin[i] = i_periph_out[i];
            end else begin
                next_oe[i]  = direction[i]; // RULE3
                next_pin[i] = output_data[i]; // RULE15
            end
            // pull only on an input pin with its converter channel off
            next_pull_on[i] = pull_enable[i] & ~next_oe[i]
                              & ~i_adc_chan_en[i]; // RULE6 RULE8 RULE9 RULE13
        end
    end

    // registered pin drive so outputs come straight from flops
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_pin         <= '0;
            o_pin_oe      <= '0;
            o_pin_reduced <= '0;
            o_pull_up_en  <= '0;
            o_pull_dn_en  <= '0;
            o_periph_in   <= '0;
        end else begin
            o_pin         <= next_pin & next_oe; // RULE15
            o_pin_oe      <= next_oe;
            o_pin_reduced <= drive_strength & next_oe; // RULE5 RULE16
            o_pull_up_en  <= next_pull_on & ~pull_polarity; // RULE10 RULE16
            o_pull_dn_en  <= next_pull_on & pull_polarity; // RULE10 RULE16
            o_periph_in   <= pin_sync; // RULE12
        end
    end

    // read mux
    always_comb begin
        next_rdata = '0;
        unique case (i_addr)
            `ADPORT_OFS_OUTPUT_DATA:
                next_rdata = (direction & output_data)
                             | (~direction & pin_sync); // RULE1
            `ADPORT_OFS_PIN_INPUT:     next_rdata = pin_sync; // RULE2
            `ADPORT_OFS_DIRECTION:     next_rdata = direction;
            `ADPORT_OFS_DRIVE:         next_rdata = drive_strength;
            `ADPORT_OFS_PULL_ENABLE:   next_rdata = pull_enable;
            `ADPORT_OFS_PULL_POLARITY: next_rdata = pull_polarity;
            default:                   next_rdata = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= '0;
        end
    end

    // assertions
    property p_pull_reset;
        @(posedge i_mclk) i_sys_rst |=> (o_pull_up_en == '0)
            && (o_pull_dn_en == '0);
    endproperty
    a_pull_reset: assert property (p_pull_reset) // RULE7
        else $error("pull active after reset");

    property p_pull_adc;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $past(i_adc_chan_en) != '0 |->
            ((o_pull_up_en | o_pull_dn_en) & $past(i_adc_chan_en)) == '0;
    endproperty
    a_pull_adc: assert property (p_pull_adc) // RULE8
        else $error("pull on with converter channel enabled");

    property p_pull_out;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ((o_pull_up_en | o_pull_dn_en) & o_pin_oe) == '0;
    endproperty
    a_pull_out: assert property (p_pull_out) // RULE13
        else $error("pull on a driven pin");

    property p_in_reg;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == `ADPORT_OFS_PIN_INPUT
            && !$past(i_sys_rst) && !$past(i_sys_rst, 2)
            |=> o_rdata == $past(i_pin, 3);
    endproperty
    a_in_reg: assert property (p_in_reg) // RULE2
        else $error("input register not pin level");

    // output bits read back their stored value, checked bit by bit
    property p_data_out;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == `ADPORT_OFS_OUTPUT_DATA
            |=> ((o_rdata ^ $past(output_data)) & $past(direction)) == '0;
    endproperty
    a_data_out: assert property (p_data_out) // RULE1
        else $error("data readback wrong for outputs");

    // a direction write lands in oe two edges on if no peripheral steps in
    sequence s_dir_wr;
        i_wr && i_addr == `ADPORT_OFS_DIRECTION && i_periph_own == '0;
    endsequence

    sequence s_gpio_hold;
        i_periph_own == '0;
    endsequence

    property p_dir_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_dir_wr ##1 s_gpio_hold |=> o_pin_oe == $past(i_wdata, 2);
    endproperty
    a_dir_write: assert property (p_dir_write) // RULE3
        else $error("direction not applied");

    property p_reduced;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (o_pin_reduced & ~o_pin_oe) == '0;
    endproperty
    a_reduced: assert property (p_reduced) // RULE5
        else $error("reduced drive on an input");

    property p_periph;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ((o_pin_oe ^ $past(i_periph_oe)) & $past(i_periph_own)) == '0;
    endproperty
    a_periph: assert property (p_periph) // RULE14
        else $error("direction not ignored under peripheral");

    // per-bit checks; p_data_in, p_oe_dir, p_red_out, p_pull_in, p_pin_drive and p_periph_drv look only at bits whose current use makes the
    // setting effective, so mixed configurations are covered as well
    property p_data_in;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && i_addr == `ADPORT_OFS_OUTPUT_DATA
            && !$past(i_sys_rst) && !$past(i_sys_rst, 2)
            |=> ((o_rdata ^ $past(i_pin, 3)) & ~$past(direction)) == '0;
    endproperty
    a_data_in: assert property (p_data_in) // RULE1
        else $error("data readback wrong for inputs");

    property p_in_nowrite;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == `ADPORT_OFS_PIN_INPUT
            |=> $stable(output_data) && $stable(direction)
                && $stable(drive_strength) && $stable(pull_enable)
                && $stable(pull_polarity);
    endproperty
    a_in_nowrite: assert property (p_in_nowrite) // RULE2
        else $error("write to input register changed a setting");

    property p_sync_lag;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && !$past(i_sys_rst, 2)
            |-> pin_sync == $past(i_pin, 2);
    endproperty
    a_sync_lag: assert property (p_sync_lag) // RULE4
        else $error("pin synchroniser lag not two cycles");

    property p_oe_dir;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ((o_pin_oe ^ $past(direction))
                 & ~$past(i_periph_own)) == '0;
    endproperty
    a_oe_dir: assert property (p_oe_dir) // RULE3
        else $error("general pin oe differs from direction");

    property p_red_out;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ((o_pin_reduced ^ $past(drive_strength))
                 & o_pin_oe) == '0;
    endproperty
    a_red_out: assert property (p_red_out) // RULE16
        else $error("drive strength of output differs from setting");

    property p_pull_sel;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ((o_pull_up_en & $past(pull_polarity)) == '0)
                && ((o_pull_dn_en & ~$past(pull_polarity)) == '0);
    endproperty
    a_pull_sel: assert property (p_pull_sel) // RULE10
        else $error("pull device of wrong polarity");

    property p_pull_en;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ((o_pull_up_en | o_pull_dn_en) & ~$past(pull_enable)) == '0;
    endproperty
    a_pull_en: assert property (p_pull_en) // RULE9
        else $error("pull on with its enable bit clear");

    property p_pull_in;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ($past(pull_enable & ~direction & ~i_periph_own
                       & ~i_adc_chan_en)
                 & ~(o_pull_up_en | o_pull_dn_en)) == '0;
    endproperty
    a_pull_in: assert property (p_pull_in) // RULE6
        else $error("enabled pull missing on an input pin");

    property p_pin_drive;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ((o_pin ^ $past(output_data))
                 & $past(direction & ~i_periph_own)) == '0;
    endproperty
    a_pin_drive: assert property (p_pin_drive) // RULE15
        else $error("output pin not driven from data register");

    property p_pin_quiet;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (o_pin & ~o_pin_oe) == '0;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) // RULE15
        else $error("drive value shown on an undriven pin");

    property p_periph_drv;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> ((o_pin ^ $past(i_periph_out))
                 & $past(i_periph_own & i_periph_oe)) == '0;
    endproperty
    a_periph_drv: assert property (p_periph_drv) // RULE12
        else $error("peripheral output not on its pin");

    property p_periph_in;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !$past(i_sys_rst)
            |-> o_periph_in == $past(pin_sync);
    endproperty
    a_periph_in: assert property (p_periph_in) // RULE12
        else $error("peripheral input not the synchronised pin");

    property p_cfg_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr && i_addr == `ADPORT_OFS_PULL_ENABLE
            |=> pull_enable == $past(wr_val);
    endproperty
    a_cfg_write: assert property (p_cfg_write) // RULE11
        else $error("pull enable write lost");

    property p_rd_idle;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_rd |=> o_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) // RULE1
        else $error("read data shown without a read strobe");

endmodule // analog_shared_gpio_port_regs

// ===== adport_pad_model.sv
`timescale 1ns/1ps

// package pins: drivers win, then pulls, then whatever the board applies
module adport_pad_model (
    // from the port
    input  wire logic [7:0] i_drv,
    input  wire logic [7:0] i_drv_oe,
    input  wire logic [7:0] i_up,
    input  wire logic [7:0] i_dn,
    // board level on undriven, unpulled pins
    input  wire logic [7:0] i_ext,
    // resolved pin level
    output logic [7:0]      o_level
);
    // a pull that fights an enabled driver loses, as on real pads
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (i_drv_oe[b]) begin
                o_level[b] = i_drv[b];
            end else if (i_up[b]) begin
                o_level[b] = 1'b1;
            end else if (i_dn[b]) begin
                o_level[b] = 1'b0;
            end else begin
                o_level[b] = i_ext[b];
            end
        end
    end
endmodule // adport_pad_model

// ===== analog_shared_gpio_port_regs_bench.sv
`timescale 1ns/1ps
`include "adport_regs.svh"

module analog_shared_gpio_port_regs_bench;
    logic                   i_mclk = 1'b0;
    logic                   i_sys_rst = 1'b1;
    adport_pkg::reg_addr_t  i_addr = 6'h00;
    adport_pkg::port_byte_t i_wdata = 8'h00;
    logic                   i_wr = 1'b0;
    logic                   i_rd = 1'b0;
    logic [7:0]             own = 8'h00, poe = 8'h00, pout = 8'h00;
    logic [7:0]             adc = 8'h00, ext = 8'h3c, pin;
    logic [7:0]             rdata, pin_drv, oe, red, up, dn, pin_in;
    int                     err_total = 0;
    int                     checked = 0;

    // 25 MHz bus clock
    always #20 i_mclk = ~i_mclk;

    analog_shared_gpio_port_regs analog_shared_gpio_port_regs_i (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_periph_own(own), .i_periph_oe(poe), .i_periph_out(pout),
        .i_adc_chan_en(adc), .o_periph_in(pin_in), .i_pin(pin),
        .o_pin(pin_drv), .o_pin_oe(oe), .o_pin_reduced(red),
        .o_pull_up_en(up), .o_pull_dn_en(dn));

    adport_pad_model adport_pad_model_i (
        .i_drv(pin_drv), .i_drv_oe(oe), .i_up(up), .i_dn(dn),
        .i_ext(ext), .o_level(pin));

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(exp, rdata);
    endtask

    // longer than the synchroniser lag so readback has caught up
    task automatic settle();
        repeat (`ADPORT_SYNC_LAG + 3) @(posedge i_mclk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog so a stuck run still reaches the verdict
    initial begin
        #400000;
        err_total++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        settle();
        chk(8'h00, up | dn);
        rd(`ADPORT_OFS_OUTPUT_DATA, 8'h3c);
        rd(`ADPORT_OFS_DIRECTION, 8'h00);
        rd(`ADPORT_OFS_DRIVE, 8'h00);
        rd(`ADPORT_OFS_PULL_ENABLE, 8'h00);
        rd(`ADPORT_OFS_PULL_POLARITY, 8'h00);
        rd(6'h36, 8'h00);
        // low nibble becomes output, data written next with one idle cycle between the writes
        wr(`ADPORT_OFS_DIRECTION, 8'h0f);
        wr(`ADPORT_OFS_OUTPUT_DATA, 8'ha5);
        wr(`ADPORT_OFS_DRIVE, 8'hff);
        wr(`ADPORT_OFS_PIN_INPUT, 8'hff);
        settle();
        chk(8'h0f, oe);
        chk(8'h05, pin_drv);
        chk(8'h0f, red);
        rd(`ADPORT_OFS_OUTPUT_DATA, 8'h35);
        rd(`ADPORT_OFS_PIN_INPUT, 8'h35);
        // pulls everywhere, converter holds pin 0
        @(posedge i_mclk);
        adc <= 8'h01;
        wr(`ADPORT_OFS_PULL_ENABLE, 8'hff);
        wr(`ADPORT_OFS_PULL_POLARITY, 8'h33);
        settle();
        chk(8'hc0, up);
        chk(8'h30, dn);
        rd(`ADPORT_OFS_PIN_INPUT, 8'hc5);
        rd(`ADPORT_OFS_PULL_ENABLE, 8'hff);
        // peripheral takes pins 7 and 0, direction bit 0 ignored
        @(posedge i_mclk);
        own <= 8'h81;
        poe <= 8'h80;
        pout <= 8'h80;
        settle();
        chk(8'h8e, oe);
        chk(8'h84, pin_drv);
        chk(8'h40, up);
        chk(8'h30, dn);
        chk(8'hc4, pin_in);
        // mid-run reset with pulls enabled must switch every pull off
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        settle();
        chk(8'h00, up | dn);
        rd(`ADPORT_OFS_PULL_ENABLE, 8'h00);
        conclude();
    end
endmodule // analog_shared_gpio_port_regs_bench
